// ### hw/block_gate_pkg.sv
// Constants shared by the functional block clock gating design
package block_gate_pkg;
  localparam logic [7:0] BLOCK_DISABLE_CONTROL_IDX = 8'h21;
  localparam logic [7:0] BLOCK_DISABLE_CONTROL_RST = 8'h00;
  localparam int DAC_DISABLE_BIT = 7;
  localparam int PLL_DISABLE_BIT = 6;
  localparam int PANEL_WRITE_DISABLE_BIT = 5;
  localparam int PANEL_READ_DISABLE_BIT = 4;
  localparam int PALETTE_DISABLE_BIT = 3;
  localparam int VIDEO_INPUT_PORT_DISABLE_BIT = 2;
  localparam int DRAWING_ENGINE_DISABLE_BIT = 1;
  localparam int VIDEO_PROCESSOR_DISABLE_BIT = 0;
  localparam int NUM_BLOCKS = 8;
  localparam logic [7:0] READ_IDLE_VALUE = 8'h00;
endpackage : block_gate_pkg

// ### hw/clock_gate_cell.sv
// Latch based glitch-free clock gate for one functional block
`timescale 1ns/100ps
`default_nettype none
module clock_gate_cell (
  // Clock and enable
  input wire logic i_clk,
  input wire logic i_enable,
  // Gated clock
  output logic o_gclk
);
  logic en_latch;

  // Enable only changes while the clock is low, so no runt pulses
  always_latch begin
    if (!i_clk) begin
      en_latch <= i_enable;
    end
  end

  assign o_gclk = i_clk & en_latch;
endmodule : clock_gate_cell
`default_nettype wire

// ### hw/functional_block_clock_gating.sv
// Block-disable control register with per-block clock gates and request masks
// Notes on behaviour
// - Register resets to zero, all blocks enabled
// - Register access works with PLL off
// - Bit 7 disables DAC, bit 6 Pll_disable
// - Panel write bit stops FIFO and request
// - Panel read bit stops FIFOs, dither, requests
// - Palette bit disables the palette RAM
// - Palette off in standby or sleep anyway
// - Video port bit blocks data, clock, request
// - Drawing engine bit switches engine off
// - Video processor bit stops whole processor
// - Register clocked by system clock only
`timescale 1ns/100ps
`default_nettype none
module functional_block_clock_gating (
  // System clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Indexed register port from the host
  input wire logic [7:0] i_reg_index,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Power mode status from the power manager
  input wire logic i_standby_mode,
  input wire logic i_sleep_mode,
  // Memory requests and video port input data from the blocks
  input wire logic i_panel_write_req,
  input wire logic i_panel_read1_req,
  input wire logic i_panel_read2_req,
  input wire logic i_video_port_req,
  input wire logic i_video_port_valid,
  input wire logic [15:0] i_video_port_data,
  // Block enables
  output logic o_dac_enable,
  output logic o_pll_enable,
  output logic o_panel_write_enable,
  output logic o_panel_read_enable,
  output logic o_dither_enable,
  output logic o_palette_enable,
  output logic o_video_port_enable,
  output logic o_drawing_engine_enable,
  output logic o_video_processor_enable,
  // Gated block clocks
  output logic [7:0] o_block_gclk,
  // Requests toward the memory arbiter
  output logic o_panel_write_req,
  output logic o_panel_read1_req,
  output logic o_panel_read2_req,
  output logic o_video_port_req,
  // Video port data after blocking
  output logic o_video_port_valid,
  output logic [15:0] o_video_port_data
);
  logic [7:0] block_disable_control_r;
  logic [7:0] block_disable_control_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] gate_en_r;
  logic [7:0] gate_en_nxt;
  logic low_power_r;
  logic low_power_nxt;
  logic vp_valid_r;
  logic vp_valid_nxt;
  logic [15:0] vp_data_r;
  logic [15:0] vp_data_nxt;
  logic std_sync1_r;
  logic std_sync2_r;
  logic slp_sync1_r;
  logic slp_sync2_r;
  logic std_sync1_nxt;
  logic std_sync2_nxt;
  logic slp_sync1_nxt;
  logic slp_sync2_nxt;

  // Index match, used by both read and write decode
  function automatic logic hit(input logic [7:0] idx);
    hit = (idx == block_gate_pkg::BLOCK_DISABLE_CONTROL_IDX);
  endfunction : hit

  // Register write and read next values
  always_comb begin
    block_disable_control_nxt = block_disable_control_r;
    rdata_nxt = rdata_r;
    if (i_reg_wr && hit(i_reg_index)) begin
      block_disable_control_nxt = i_reg_wdata;
    end
    if (i_reg_rd && hit(i_reg_index)) begin
      rdata_nxt = block_disable_control_r;
    end else if (i_reg_rd) begin
      rdata_nxt = block_gate_pkg::READ_IDLE_VALUE;
    end
  end

  // Register storage; only the system clock, never a PLL clock
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      block_disable_control_r <= block_gate_pkg::BLOCK_DISABLE_CONTROL_RST;
      rdata_r <= block_gate_pkg::READ_IDLE_VALUE;
    end else begin
      block_disable_control_r <= block_disable_control_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;

  // Power mode levels may come from another domain, so synchronise them
  always_comb begin
    std_sync1_nxt = i_standby_mode;
    std_sync2_nxt = std_sync1_r;
    slp_sync1_nxt = i_sleep_mode;
    slp_sync2_nxt = slp_sync1_r;
  end

  // Only the second stage feeds other logic, so a metastable first stage stays contained
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      std_sync1_r <= 1'b0;
      std_sync2_r <= 1'b0;
      slp_sync1_r <= 1'b0;
      slp_sync2_r <= 1'b0;
    end else begin
      std_sync1_r <= std_sync1_nxt;
      std_sync2_r <= std_sync2_nxt;
      slp_sync1_r <= slp_sync1_nxt;
      slp_sync2_r <= slp_sync2_nxt;
    end
  end

  // Enables are registered so the gates see clean, single-edge changes
  always_comb begin
    low_power_nxt = std_sync2_r | slp_sync2_r;
    gate_en_nxt = ~block_disable_control_r;
    // Palette off in low power regardless of the software bit
    gate_en_nxt[block_gate_pkg::PALETTE_DISABLE_BIT] =
      ~block_disable_control_r[block_gate_pkg::PALETTE_DISABLE_BIT] & ~low_power_r;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      gate_en_r <= ~block_gate_pkg::BLOCK_DISABLE_CONTROL_RST;
      low_power_r <= 1'b0;
    end else begin
      gate_en_r <= gate_en_nxt;
      low_power_r <= low_power_nxt;
    end
  end

  // One latch-based gate per block
  genvar g;
  generate
    for (g = 0; g < block_gate_pkg::NUM_BLOCKS; g++) begin : gate_gen
      clock_gate_cell u_gate (
        .i_clk(i_clk),
        .i_enable(gate_en_r[g]),
        .o_gclk(o_block_gclk[g])
      );
    end
  endgenerate

  assign o_dac_enable = gate_en_r[block_gate_pkg::DAC_DISABLE_BIT];
  assign o_pll_enable = gate_en_r[block_gate_pkg::PLL_DISABLE_BIT];
  assign o_panel_write_enable = gate_en_r[block_gate_pkg::PANEL_WRITE_DISABLE_BIT];
  assign o_panel_read_enable = gate_en_r[block_gate_pkg::PANEL_READ_DISABLE_BIT];
  assign o_dither_enable = gate_en_r[block_gate_pkg::PANEL_READ_DISABLE_BIT];
  assign o_palette_enable = gate_en_r[block_gate_pkg::PALETTE_DISABLE_BIT];
  assign o_video_port_enable = gate_en_r[block_gate_pkg::VIDEO_INPUT_PORT_DISABLE_BIT];
  assign o_drawing_engine_enable = gate_en_r[block_gate_pkg::DRAWING_ENGINE_DISABLE_BIT];
  assign o_video_processor_enable = gate_en_r[block_gate_pkg::VIDEO_PROCESSOR_DISABLE_BIT];

  // Request masks are combinational handshakes toward the arbiter
  assign o_panel_write_req = i_panel_write_req & o_panel_write_enable;
  assign o_panel_read1_req = i_panel_read1_req & o_panel_read_enable;
  assign o_panel_read2_req = i_panel_read2_req & o_panel_read_enable;
  assign o_video_port_req = i_video_port_req & o_video_port_enable;

  // Video port data is blocked while the port is disabled
  always_comb begin
    vp_valid_nxt = i_video_port_valid & o_video_port_enable;
    vp_data_nxt = vp_data_r;
    if (vp_valid_nxt) begin
      vp_data_nxt = i_video_port_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      vp_valid_r <= 1'b0;
      vp_data_r <= 16'h0000;
    end else begin
      vp_valid_r <= vp_valid_nxt;
      vp_data_r <= vp_data_nxt;
    end
  end

  assign o_video_port_valid = vp_valid_r;
  assign o_video_port_data = vp_data_r;

  // Checks
  // Multi-step behaviours are built from these named sequences
  sequence wr_hit_s;
    i_reg_wr && hit(i_reg_index);
  endsequence

  sequence wr_miss_s;
    i_reg_wr && !hit(i_reg_index);
  endsequence

  sequence rd_hit_s;
    i_reg_rd && hit(i_reg_index);
  endsequence

  sequence rd_miss_s;
    i_reg_rd && !hit(i_reg_index);
  endsequence

  sequence low_power_s;
    std_sync2_r || slp_sync2_r;
  endsequence

  sequence vp_accept_s;
    o_video_port_enable && i_video_port_valid;
  endsequence

  // Reset values and register access
  reset_zero_a: assert property (@(posedge i_clk)
    $fell(i_sys_rst) |-> block_disable_control_r == block_gate_pkg::BLOCK_DISABLE_CONTROL_RST)
    else $error("register not zero after reset");
  reset_enables_a: assert property (@(posedge i_clk)
    $fell(i_sys_rst) |-> gate_en_r == ~block_gate_pkg::BLOCK_DISABLE_CONTROL_RST)
    else $error("block enables not all on after reset");
  reset_outputs_a: assert property (@(posedge i_clk)
    $fell(i_sys_rst) |-> !o_video_port_valid &&
      o_reg_rdata == block_gate_pkg::READ_IDLE_VALUE)
    else $error("outputs not idle after reset");
  write_store_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wr_hit_s |=> block_disable_control_r == $past(i_reg_wdata))
    else $error("register write lost");
  write_miss_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wr_miss_s |=> $stable(block_disable_control_r))
    else $error("write to other index changed register");
  read_back_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    rd_hit_s |=> o_reg_rdata == $past(block_disable_control_r))
    else $error("read value wrong");
  read_miss_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    rd_miss_s |=> o_reg_rdata == block_gate_pkg::READ_IDLE_VALUE)
    else $error("read of other index not idle value");
  rdata_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without a read");

  // Block enables follow the register one cycle later; the palette is also forced off in low power
  dac_gate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ##1 o_dac_enable == !$past(block_disable_control_r[block_gate_pkg::DAC_DISABLE_BIT]))
    else $error("dac enable wrong");
  pll_gate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ##1 o_pll_enable == !$past(block_disable_control_r[block_gate_pkg::PLL_DISABLE_BIT]))
    else $error("pll enable wrong");
  pw_gate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ##1 o_panel_write_enable ==
      !$past(block_disable_control_r[block_gate_pkg::PANEL_WRITE_DISABLE_BIT]))
    else $error("panel write enable wrong");
  dither_gate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ##1 o_dither_enable ==
      !$past(block_disable_control_r[block_gate_pkg::PANEL_READ_DISABLE_BIT]))
    else $error("dither enable wrong");
  vproc_gate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ##1 o_video_processor_enable ==
      !$past(block_disable_control_r[block_gate_pkg::VIDEO_PROCESSOR_DISABLE_BIT]))
    else $error("video processor enable wrong");
  palette_bit_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    block_disable_control_r[block_gate_pkg::PALETTE_DISABLE_BIT] |=> !o_palette_enable)
    else $error("palette on with its bit set");
  palette_on_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!block_disable_control_r[block_gate_pkg::PALETTE_DISABLE_BIT] && !low_power_r) |=>
      o_palette_enable)
    else $error("palette off with its bit clear");
  palette_lp_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    low_power_s |=> ##1 !o_palette_enable)
    else $error("palette on in low power");

  // Requests and port data are masked by the enables; the drawing engine enable follows a register write
  pw_req_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !o_panel_write_enable |-> !o_panel_write_req)
    else $error("panel write request leaked");
  pr_req_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !o_panel_read_enable |-> !(o_panel_read1_req || o_panel_read2_req || o_dither_enable))
    else $error("panel read path active");
  vport_req_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !o_video_port_enable |-> !o_video_port_req)
    else $error("video port request leaked");
  vp_block_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !o_video_port_enable |=> !o_video_port_valid)
    else $error("video data not blocked");
  vp_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !o_video_port_enable |=> $stable(o_video_port_data))
    else $error("video data moved while port off");
  vp_pass_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    vp_accept_s |=> o_video_port_valid && o_video_port_data == $past(i_video_port_data))
    else $error("video data not passed");
  de_gate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wr_hit_s ##1 1'b1 |=> o_drawing_engine_enable ==
      !$past(block_disable_control_r[block_gate_pkg::DRAWING_ENGINE_DISABLE_BIT]))
    else $error("drawing engine enable wrong");
endmodule : functional_block_clock_gating
`default_nettype wire

// ### tb/host_cpu_model.sv
// Host CPU model issuing indexed register cycles
`timescale 1ns/100ps
`default_nettype none
module host_cpu_model (
  // Clock
  input wire logic i_clk,
  // Indexed register port
  output logic [7:0] o_index,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata
);
  // Bus idles with both strobes low
  initial begin
    o_index = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // One-cycle strobe; index and data inverted after so stale values never match
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_index = idx;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    o_index = ~idx;
    o_wdata = ~d;
  endtask : wr_reg
  // Read data is registered, so it is taken just after the closing edge
  task automatic rd_reg(input logic [7:0] idx, output logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_index = idx;
    o_rd = 1'b1;
    @(posedge i_clk);
    #1;
    o_rd = 1'b0;
    o_index = ~idx;
    d = i_rdata;
  endtask : rd_reg
endmodule : host_cpu_model
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the block disable register
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic standby = 1'b0;
  logic sleep = 1'b0;
  logic req = 1'b1;
  logic vvalid = 1'b1;
  logic [15:0] vdata = 16'h5a3c;
  logic [7:0] idx, wdata, rdata, rval, gclk;
  logic wr, rd, ovalid;
  logic [8:0] en;
  logic [3:0] mreq;
  logic [15:0] odata;
  logic [7:0] pats [4] = '{8'hff, 8'h30, 8'h03, 8'h20};
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  // Free-running system clock
  always #5 clk = ~clk;
  host_cpu_model host (.i_clk(clk), .o_index(idx), .o_wr(wr), .o_rd(rd), .o_wdata(wdata),
    .i_rdata(rdata));
  functional_block_clock_gating dut (.i_clk(clk), .i_sys_rst(rst), .i_reg_index(idx),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_standby_mode(standby), .i_sleep_mode(sleep), .i_panel_write_req(req),
    .i_panel_read1_req(req), .i_panel_read2_req(req), .i_video_port_req(req),
    .i_video_port_valid(vvalid), .i_video_port_data(vdata), .o_dac_enable(en[8]),
    .o_pll_enable(en[7]), .o_panel_write_enable(en[6]), .o_panel_read_enable(en[5]),
    .o_dither_enable(en[4]), .o_palette_enable(en[3]), .o_video_port_enable(en[2]),
    .o_drawing_engine_enable(en[1]), .o_video_processor_enable(en[0]), .o_block_gclk(gclk),
    .o_panel_write_req(mreq[3]), .o_panel_read1_req(mreq[2]), .o_panel_read2_req(mreq[1]),
    .o_video_port_req(mreq[0]), .o_video_port_valid(ovalid), .o_video_port_data(odata));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // Enables settle two edges after the write; gate and port valid show it one edge later
  task automatic check_state(input logic [7:0] v);
    vdata = {v, ~v};
    @(posedge clk);
    #1;
    chk("enables", {~v[7:4], ~v[4:0]}, en);
    chk("requests", {~v[5], ~v[4], ~v[4], ~v[2]}, mreq);
    @(posedge clk);
    #2;
    chk("gated clocks", {~v}, gclk);
    chk("port valid", {~v[2]}, ovalid);
    if (v[2] == 1'b0) chk("port data", vdata, odata);
    host.rd_reg(8'h21, rval);
    chk("readback", v, rval);
  endtask : check_state
  // Hang guard sized well above the whole sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    check_state(8'h00);
    $display("test reset done");
    for (int b = 0; b < 8; b++) begin
      host.wr_reg(8'h21, 8'h01 << b);
      check_state(8'h01 << b);
    end
    // Software settings for dual view, unused panel and VGA mode
    foreach (pats[i]) begin
      host.wr_reg(8'h21, pats[i]);
      check_state(pats[i]);
    end
    $display("test bits done");
    host.wr_reg(8'h21, 8'h00);
    host.wr_reg(8'h20, 8'hff);
    check_state(8'h00);
    host.rd_reg(8'h22, rval);
    chk("unmapped read", 8'h00, rval);
    $display("test unmapped done");
    // Low-power modes force the palette off regardless of its bit
    for (int m = 0; m < 2; m++) begin
      standby = (m == 0);
      sleep = (m == 1);
      repeat (6) @(posedge clk);
      #1;
      chk("palette low power", 1'b0, en[3]);
      chk("dac low power", 1'b1, en[8]);
      standby = 1'b0;
      sleep = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk("palette awake", 1'b1, en[3]);
    end
    $display("test power modes done");
    // With every block enabled, idle inputs must give idle requests and no port data
    req = 1'b0;
    vvalid = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("idle requests", 4'h0, mreq);
    chk("idle port valid", 1'b0, ovalid);
    req = 1'b1;
    vvalid = 1'b1;
    $display("test request masks done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
